// ==== core/pwm_gen_a_cfg.svh ====
// Purpose: constants for the output A action block
// Assumes: apb byte addressing, 32-bit data
// Notes:   offsets are byte addresses
`ifndef PWM_GEN_A_CFG_SVH
`define PWM_GEN_A_CFG_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define GEN_A_ACTIONS_OFFSET 12'h060
`define GEN_CONTROL_OFFSET   12'h040
`define GEN_A_STATUS_OFFSET  12'h044

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ZERO_ACT_LSB  0
`define LOAD_ACT_LSB  2
`define CAU_ACT_LSB   4
`define CAD_ACT_LSB   6
`define CBU_ACT_LSB   8
`define CBD_ACT_LSB   10
`define ACT_FIELDS_W  12
`define MODE_BIT      0
`define STATUS_BIT    0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ACTIONS_RESET 12'h000
`define OUT_A_RESET   1'b0
`define MODE_RESET    1'b0
`define RDATA_RESET   32'h0000_0000

`endif

// ==== core/pwm_gen_a_pkg.sv ====
// Purpose: types for the output A action block
// Assumes: nothing
// Notes:   action codes as stored in the register fields
package pwm_gen_a_pkg;

	typedef enum logic [1:0]
	{
		act_none   = 2'h0,
		act_toggle = 2'h1,
		act_low    = 2'h2,
		act_high   = 2'h3
	} action_t;

endpackage

// ==== core/pwm_output_a_action_control.sv ====
// Purpose: output A action logic of one pwm generator, apb registers
// Assumes: counter and comparators outside; event inputs are pulses
// Notes:   one output update per clock, from the winning event
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_gen_a_cfg.svh"

// Contract
// - Comparator B match while counting up applies action bits 9:8.
// - Up-count compare events exist only when mode bit is 1.
// - Comparator A match while counting down applies action bits 7:6.
// - Comparator A match while counting up applies action bits 5:4.
// - Counter equal to load applies action bits 3:2.
// - Counter reaching zero applies action bits 1:0.
// - Codes: 0 hold, 1 toggle, 2 drive low, 3 drive high.
// - Zero or load event beats any coincident compare event.
// - Comparator A event beats a coincident comparator B event.
// - Down-only mode yields three event types; up/down yields five.
module pwm_output_a_action_control
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cnt_zero,
	input  wire logic        cnt_load,
	input  wire logic        cmp_a_match,
	input  wire logic        cmp_b_match,
	input  wire logic        count_down,
	output logic             generator_output_a
);

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic [`ACT_FIELDS_W-1:0] actions_reg;
	logic [`ACT_FIELDS_W-1:0] actions_next;
	logic                     mode_reg;
	logic                     mode_next;
	logic [31:0]              prdata_reg;
	logic [31:0]              prdata_next;
	logic                     out_a_reg;
	logic                     out_a_next;
	logic                     access;
	logic                     wr_en;
	logic                     known;

	assign access  = psel & penable;
	assign wr_en   = access & pwrite;
	assign pready  = 1'b1;
	// zero wait states; unmapped addresses answer with an error
	assign known   = (paddr == `GEN_A_ACTIONS_OFFSET) |
	                 (paddr == `GEN_CONTROL_OFFSET) |
	                 (paddr == `GEN_A_STATUS_OFFSET);
	assign pslverr = access & ~known;
	assign prdata  = prdata_reg;

	always_comb
	begin
		actions_next = actions_reg;
		mode_next    = mode_reg;
		prdata_next  = prdata_reg;
		if (wr_en && paddr == `GEN_A_ACTIONS_OFFSET)
			actions_next = pwdata[`ACT_FIELDS_W-1:0];
		if (wr_en && paddr == `GEN_CONTROL_OFFSET)
			mode_next = pwdata[`MODE_BIT];
		if (psel && !penable && !pwrite)
		begin
			// read data registered in setup, valid in access phase
			prdata_next = 32'h0000_0000;
			case (paddr)
				`GEN_A_ACTIONS_OFFSET:
					prdata_next[`ACT_FIELDS_W-1:0] = actions_reg;
				`GEN_CONTROL_OFFSET:
					prdata_next[`MODE_BIT] = mode_reg;
				`GEN_A_STATUS_OFFSET:
					prdata_next[`STATUS_BIT] = out_a_reg;
				default:
					prdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			actions_reg <= `ACTIONS_RESET;
			mode_reg    <= `MODE_RESET;
			prdata_reg  <= `RDATA_RESET;
		end
		else
		begin
			actions_reg <= actions_next;
			mode_reg    <= mode_next;
			prdata_reg  <= prdata_next;
		end
	end

	// ------------------------------------------------------------
	// event qualification and priority
	// ------------------------------------------------------------
	logic ev_cau;
	logic ev_cad;
	logic ev_cbu;
	logic [1:0] sel_act;
	logic       sel_valid;

	// up-count compares only exist in up/down mode
	assign ev_cau = cmp_a_match & ~count_down & mode_reg;
	assign ev_cbu = cmp_b_match & ~count_down & mode_reg;
	assign ev_cad = cmp_a_match & count_down;
	// b-down field is stored only; no event of it reaches output a

	always_comb
	begin
		sel_act   = 2'h0;
		sel_valid = 1'b1;
		// zero and load outrank compares; a outranks b
		if (cnt_zero)
			sel_act = actions_reg[`ZERO_ACT_LSB +: 2];
		else if (cnt_load)
			sel_act = actions_reg[`LOAD_ACT_LSB +: 2];
		else if (ev_cau)
			sel_act = actions_reg[`CAU_ACT_LSB +: 2];
		else if (ev_cad)
			sel_act = actions_reg[`CAD_ACT_LSB +: 2];
		else if (ev_cbu)
			sel_act = actions_reg[`CBU_ACT_LSB +: 2];
		else
			sel_valid = 1'b0;
	end

	// ------------------------------------------------------------
	// output flop
	// ------------------------------------------------------------
	always_comb
	begin
		out_a_next = out_a_reg;
		if (sel_valid)
		begin
			case (pwm_gen_a_pkg::action_t'(sel_act))
				pwm_gen_a_pkg::act_toggle: out_a_next = ~out_a_reg;
				pwm_gen_a_pkg::act_low:    out_a_next = 1'b0;
				pwm_gen_a_pkg::act_high:   out_a_next = 1'b1;
				default:                   out_a_next = out_a_reg;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_a_reg <= `OUT_A_RESET;
		else
			out_a_reg <= out_a_next;
	end

	assign generator_output_a = out_a_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [1:0] f_zero;
	logic [1:0] f_load;
	logic [1:0] f_cau;
	logic [1:0] f_cad;
	logic [1:0] f_cbu;
	assign f_zero = actions_reg[`ZERO_ACT_LSB +: 2];
	assign f_load = actions_reg[`LOAD_ACT_LSB +: 2];
	assign f_cau  = actions_reg[`CAU_ACT_LSB +: 2];
	assign f_cad  = actions_reg[`CAD_ACT_LSB +: 2];
	assign f_cbu  = actions_reg[`CBU_ACT_LSB +: 2];

	sequence s_zero_high;
		cnt_zero && f_zero == 2'h3;
	endsequence

	sequence s_zero_low;
		cnt_zero && f_zero == 2'h2;
	endsequence

	sequence s_load_high;
		!cnt_zero && cnt_load && f_load == 2'h3;
	endsequence

	sequence s_load_low;
		!cnt_zero && cnt_load && f_load == 2'h2;
	endsequence

	// compares only act when neither zero nor load fires
	sequence s_cmp_only;
		!cnt_zero && !cnt_load;
	endsequence

	a_zero_drives_high:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_zero_high |=> generator_output_a)
		else $error("zero high action not applied");

	a_zero_drives_low:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_zero_low |=> !generator_output_a)
		else $error("zero low action not applied");

	a_zero_holds:
	assert property (@(posedge pclk) disable iff (!presetn)
		cnt_zero && f_zero == 2'h0 |=> $stable(generator_output_a))
		else $error("zero hold action moved the output");

	a_zero_toggles:
	assert property (@(posedge pclk) disable iff (!presetn)
		cnt_zero && f_zero == 2'h1
		|=> generator_output_a != $past(generator_output_a))
		else $error("zero toggle action not applied");

	a_load_drives_high:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_load_high |=> generator_output_a)
		else $error("load high action not applied");

	a_load_drives_low:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_load_low |=> !generator_output_a)
		else $error("load low action not applied");

	// ------------------------------------------------------------
	// priority between coincident events
	// ------------------------------------------------------------
	a_load_over_cmp:
	assert property (@(posedge pclk) disable iff (!presetn)
		!cnt_zero && cnt_load && cmp_a_match && f_load == 2'h0
		|=> $stable(generator_output_a))
		else $error("compare action leaked past load event");

	a_zero_over_cmp:
	assert property (@(posedge pclk) disable iff (!presetn)
		cnt_zero && cmp_b_match && f_zero == 2'h0
		|=> $stable(generator_output_a))
		else $error("compare action leaked past zero event");

	a_a_beats_b:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_cmp_only ##0 (cmp_a_match && cmp_b_match && !count_down
		&& mode_reg && f_cau == 2'h0) |=> $stable(generator_output_a))
		else $error("cmp b action taken over cmp a");

	// ------------------------------------------------------------
	// compare actions, written from the pins
	// ------------------------------------------------------------
	a_cmp_a_up:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_cmp_only ##0 (cmp_a_match && !count_down && mode_reg
		&& f_cau == 2'h1)
		|=> generator_output_a != $past(generator_output_a))
		else $error("cmp a up toggle missing");

	a_cmp_a_up_high:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_cmp_only ##0 (cmp_a_match && !count_down && mode_reg
		&& f_cau == 2'h3) |=> generator_output_a)
		else $error("cmp a up high action missing");

	a_cmp_a_down:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_cmp_only ##0 (cmp_a_match && count_down && f_cad == 2'h3)
		|=> generator_output_a)
		else $error("cmp a down action missing");

	a_cmp_a_down_low:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_cmp_only ##0 (cmp_a_match && count_down && f_cad == 2'h2)
		|=> !generator_output_a)
		else $error("cmp a down low action missing");

	a_cmp_b_up:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_cmp_only ##0 (!cmp_a_match && cmp_b_match && !count_down
		&& mode_reg && f_cbu == 2'h2) |=> !generator_output_a)
		else $error("cmp b up action missing");

	a_cmp_b_up_high:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_cmp_only ##0 (!cmp_a_match && cmp_b_match && !count_down
		&& mode_reg && f_cbu == 2'h3) |=> generator_output_a)
		else $error("cmp b up high action missing");

	a_down_mode_no_up:
	assert property (@(posedge pclk) disable iff (!presetn)
		!mode_reg && !cnt_zero && !cnt_load && !count_down
		|=> $stable(generator_output_a))
		else $error("up event acted in down-only mode");

	// b-down is outside this block, so it must stay silent
	a_b_down_ignored:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_cmp_only ##0 (!cmp_a_match && count_down)
		|=> $stable(generator_output_a))
		else $error("cmp b down moved the output");

	// ------------------------------------------------------------
	// idle and reset
	// ------------------------------------------------------------
	a_idle_stable:
	assert property (@(posedge pclk) disable iff (!presetn)
		!cnt_zero && !cnt_load && !cmp_a_match && !cmp_b_match
		|=> $stable(generator_output_a))
		else $error("output moved without an event");

	// a stale level after release would glitch the power stage
	a_reset_low:
	assert property (@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> !generator_output_a)
		else $error("output not low after reset");

endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the output A action block
// Assumes: zero-wait apb slave, one-cycle event pulses
// Notes:   expected levels worked out from the action code table
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        out_a;
	logic        er;
	logic [4:0]  ev = 5'h00; // zero, load, cmp a, cmp b, down
	int          n_errors = 0;
	int          samples_checked = 0;
	localparam logic [9:0] code_seq = 10'h217;
	localparam logic [4:0] code_exp = 5'h0d;
	localparam logic [24:0] src_ev = {5'h02, 5'h05, 5'h04, 5'h08, 5'h10};

	always #4 pclk = ~pclk;

	pwm_output_a_action_control i_pwm_output_a_action_control
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cnt_zero(ev[4]),
		.cnt_load(ev[3]), .cmp_a_match(ev[2]), .cmp_b_match(ev[1]),
		.count_down(ev[0]), .generator_output_a(out_a)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// data taken at the pready edge, before any update of that edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16)
		begin
			n_errors++;
			tally_and_finish();
		end
	endtask

	// one-cycle event, output judged after the edge that takes it
	task fire(input logic [4:0] e, input logic exp);
		@(posedge pclk);
		ev <= e;
		@(posedge pclk);
		ev <= 5'h00;
		#1;
		chk({31'h0, out_a}, {31'h0, exp});
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_regs;
		apb(1'b0, 12'h060, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h060, 32'hffffffff);
		apb(1'b0, 12'h060, 32'h0);
		chk(rd, 32'h00000fff);
		apb(1'b0, 12'h07c, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, 12'h060, 32'h0);
	endtask

	task t_codes;
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, 12'h060, {30'h0, code_seq[2*i +: 2]});
			fire(5'h10, code_exp[i]);
		end
	endtask

	task t_sources;
		apb(1'b1, 12'h040, 32'h1);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, 12'h060, 32'h3 << (2*i));
			fire(src_ev[5*i +: 5], 1'b1);
			apb(1'b0, 12'h044, 32'h0);
			chk(rd, 32'h1);
			apb(1'b1, 12'h060, 32'h2 << (2*i));
			fire(src_ev[5*i +: 5], 1'b0);
		end
		apb(1'b1, 12'h060, 32'h300);
		fire(5'h03, 1'b0);
	endtask

	// down-only mode must swallow both up-count compares
	task t_mode;
		apb(1'b1, 12'h040, 32'h0);
		apb(1'b1, 12'h060, 32'h330);
		fire(5'h04, 1'b0);
		fire(5'h02, 1'b0);
		apb(1'b1, 12'h060, 32'h0c0);
		fire(5'h05, 1'b1);
	endtask

	task t_prio;
		apb(1'b1, 12'h040, 32'h1);
		apb(1'b1, 12'h060, 32'h332);
		fire(5'h16, 1'b0);
		apb(1'b1, 12'h060, 32'h22c);
		fire(5'h0e, 1'b1);
		apb(1'b1, 12'h060, 32'h320);
		fire(5'h06, 1'b0);
		apb(1'b1, 12'h060, 32'h300);
		fire(5'h12, 1'b0);
		apb(1'b1, 12'h060, 32'h030);
		fire(5'h0c, 1'b0);
		apb(1'b1, 12'h060, 32'h300);
		fire(5'h06, 1'b0);
		apb(1'b1, 12'h060, 32'h010);
		fire(5'h04, 1'b1);
		fire(5'h04, 1'b0);
		apb(1'b1, 12'h060, 32'h003);
		fire(5'h10, 1'b1);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		#1;
		chk({31'h0, out_a}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h060, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		chk(rd, 32'h0);
	endtask

	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_codes();
		t_sources();
		t_mode();
		t_prio();
		tally_and_finish();
	end
endmodule
`default_nettype wire
